// ### internal_error_report_mask.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ierr_mask_cfg.svh"
module internal_error_report_mask (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire ierr_mask_pkg::apb_req_s apbReq,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [31:0] errDetect,
  output ierr_mask_pkg::err_report_s errReport,
  output logic [31:0] forwardedErr
);
  import ierr_mask_pkg::*;

  // =====================================================
  // Helper functions

  // Compare the bus address with one register offset
  function automatic logic addrIs(
    input logic [11:0] addr,
    input logic [11:0] offset
  );
    addrIs = (addr == offset);
  endfunction

  // One-hot word for a single field position
  function automatic word_t fieldBit(
    input int unsigned pos
  );
    fieldBit = 32'h00000001 << pos;
  endfunction

  // Read-write field: take write data, keep reserved bits low
  function automatic word_t fieldWrite(
    input logic doWrite,
    input word_t current,
    input word_t wdata,
    input word_t keepBits
  );
    fieldWrite = doWrite ? (wdata & keepBits) : current;
  endfunction

  // Sticky status: write-one clears, detection sets, set wins
  function automatic word_t stickyNext(
    input word_t current,
    input word_t clearBits,
    input word_t setBits,
    input word_t keepBits
  );
    stickyNext = ((current & ~clearBits) | setBits) & keepBits;
  endfunction

  // Status bits of one group that the mask lets through
  function automatic word_t passMasked(
    input word_t status,
    input word_t mask,
    input word_t group
  );
    passMasked = status & ~mask & group;
  endfunction

  // Pick the register word addressed by a read
  function automatic word_t readSelect(
    input logic [3:0] sel,
    input word_t ctlWord,
    input word_t stsWord,
    input word_t mskWord,
    input word_t sevWord
  );
    readSelect = 32'h00000000;
    if (sel[0]) begin
      readSelect = ctlWord;
    end else if (sel[1]) begin
      readSelect = stsWord;
    end else if (sel[2]) begin
      readSelect = mskWord;
    end else if (sel[3]) begin
      readSelect = sevWord;
    end
  endfunction

  // True when any bit of a word is set
  function automatic logic anySet(
    input word_t value
  );
    anySet = |value;
  endfunction

  // =====================================================
  // Field map

  // Time-out fields, ingress then egress, bit 3 left out
  word_t timeoutFields;
  assign timeoutFields =
    fieldBit(`IERR_POS_INGRESS_POSTED_TIMEOUT) |
    fieldBit(`IERR_POS_INGRESS_NONPOSTED_TIMEOUT) |
    fieldBit(`IERR_POS_INGRESS_COMPLETION_TIMEOUT) |
    fieldBit(`IERR_POS_EGRESS_POSTED_TIMEOUT) |
    fieldBit(`IERR_POS_EGRESS_NONPOSTED_TIMEOUT) |
    fieldBit(`IERR_POS_EGRESS_COMPLETION_TIMEOUT);

  // Buffer RAM ECC fields, single then double
  word_t eccFields;
  assign eccFields =
    fieldBit(`IERR_POS_INGRESS_DATA_SINGLE_ECC) |
    fieldBit(`IERR_POS_INGRESS_DATA_DOUBLE_ECC) |
    fieldBit(`IERR_POS_INGRESS_CTRL_SINGLE_ECC) |
    fieldBit(`IERR_POS_INGRESS_CTRL_DOUBLE_ECC) |
    fieldBit(`IERR_POS_EGRESS_DATA_SINGLE_ECC) |
    fieldBit(`IERR_POS_EGRESS_DATA_DOUBLE_ECC) |
    fieldBit(`IERR_POS_EGRESS_CTRL_SINGLE_ECC) |
    fieldBit(`IERR_POS_EGRESS_CTRL_DOUBLE_ECC);

  // Parity, unreliable link and replay RAM ECC fields
  word_t otherFields;
  assign otherFields =
    fieldBit(`IERR_POS_END_TO_END_PARITY_ERROR) |
    fieldBit(`IERR_POS_UNRELIABLE_LINK_FLAG) |
    fieldBit(`IERR_POS_REPLAY_CTRL_SINGLE_ECC) |
    fieldBit(`IERR_POS_REPLAY_CTRL_DOUBLE_ECC);

  // Every implemented field; reserved bits stay out
  word_t validBits;
  assign validBits = timeoutFields | eccFields | otherFields;

  // =====================================================
  // Bus decode

  // Phase qualifiers of the current transfer
  logic setupPhase;
  logic accessPhase;
  logic wrStrobe;
  logic rdSetup;
  assign setupPhase = apbReq.psel & ~apbReq.penable;
  assign accessPhase = apbReq.psel & apbReq.penable;
  assign wrStrobe = accessPhase & apbReq.pwrite;
  assign rdSetup = setupPhase & ~apbReq.pwrite;

  // Register selects
  logic selCtl;
  logic selSts;
  logic selMsk;
  logic selSev;
  logic hit;
  assign selCtl = addrIs(apbReq.paddr, `IERR_CTL_OFFSET);
  assign selSts = addrIs(apbReq.paddr, `IERR_STS_OFFSET);
  assign selMsk = addrIs(apbReq.paddr, `IERR_MSK_OFFSET);
  assign selSev = addrIs(apbReq.paddr, `IERR_SEV_OFFSET);
  assign hit = selCtl | selSts | selMsk | selSev;

  // Per-register write strobes, taken in the access phase
  logic wrCtl;
  logic wrSts;
  logic wrMsk;
  logic wrSev;
  assign wrCtl = wrStrobe & selCtl;
  assign wrSts = wrStrobe & selSts;
  assign wrMsk = wrStrobe & selMsk;
  assign wrSev = wrStrobe & selSev;

  // No wait states; an unmapped access flags an error
  assign pready = 1'b1;
  assign pslverr = accessPhase & ~hit;

  // =====================================================
  // Reporting enable

  // Single enable bit that gates both errReport levels but not forwardedErr
  logic enable_reg;
  logic enable_next;
  assign enable_next = wrCtl ?
    apbReq.pwdata[`IERR_CTL_EN_BIT] : enable_reg;

  // Enable register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      enable_reg <= `IERR_CTL_EN_RESET;
    end else begin
      enable_reg <= enable_next;
    end
  end

  // =====================================================
  // Error status

  // Detection pulses on implemented fields only
  word_t newEvents;
  assign newEvents = errDetect & validBits;

  // Write-one-clear pattern, only from a status write
  word_t statusClear;
  assign statusClear = wrSts ? apbReq.pwdata : 32'h00000000;

  // Mask takes no part, so status holds whatever the mask
  word_t status_reg;
  word_t status_next;
  assign status_next = stickyNext(status_reg, statusClear,
    newEvents, validBits);

  // Status register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      status_reg <= `IERR_STS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // =====================================================
  // Report mask

  // Mask fields, reserved bits ignore writes
  word_t mask_reg;
  word_t mask_next;
  assign mask_next = fieldWrite(wrMsk, mask_reg, apbReq.pwdata,
    validBits);

  // Mask register, all fields clear after reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mask_reg <= `IERR_MSK_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // =====================================================
  // Severity

  // Severity fields, reserved bits ignore writes
  word_t sev_reg;
  word_t sev_next;
  assign sev_next = fieldWrite(wrSev, sev_reg, apbReq.pwdata,
    validBits);

  // Severity register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sev_reg <= `IERR_SEV_RESET;
    end else begin
      sev_reg <= sev_next;
    end
  end

  // =====================================================
  // Read path

  // Control word view, enable in bit 0
  word_t ctlView;
  assign ctlView = {31'h00000000, enable_reg};

  // Register select vector and addressed word
  logic [3:0] selVec;
  word_t rdSelect;
  assign selVec = {selSev, selMsk, selSts, selCtl};
  assign rdSelect = readSelect(selVec, ctlView, status_reg, mask_reg,
    sev_reg);

  // Capture in the setup cycle of a read, hold otherwise
  word_t rd_reg;
  word_t rd_next;
  assign rd_next = rdSetup ? rdSelect : rd_reg;
  assign prdata = rd_reg;

  // Read data register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_reg <= 32'h00000000;
    end else begin
      rd_reg <= rd_next;
    end
  end

  // =====================================================
  // Reporting toward the capability

  // Set and unmasked status bits, one group at a time
  word_t liveTimeout;
  word_t liveEcc;
  word_t liveOther;
  word_t unmasked;
  assign liveTimeout = passMasked(status_reg, mask_reg, timeoutFields);
  assign liveEcc = passMasked(status_reg, mask_reg, eccFields);
  assign liveOther = passMasked(status_reg, mask_reg, otherFields);
  assign unmasked = liveTimeout | liveEcc | liveOther;
  assign forwardedErr = unmasked;

  // Split by severity
  word_t urgentBits;
  word_t mildBits;
  assign urgentBits = unmasked & sev_reg;
  assign mildBits = unmasked & ~sev_reg;

  // Report levels, both held off while reporting is disabled
  logic raiseUncorr;
  logic raiseCorr;
  assign raiseUncorr = enable_reg & anySet(urgentBits);
  assign raiseCorr = enable_reg & anySet(mildBits);
  assign errReport = '{
    uncorrectable: raiseUncorr,
    correctable: raiseCorr
  };
endmodule
`default_nettype wire

// ### ierr_mask_cfg.svh
`ifndef IERR_MASK_CFG_SVH
`define IERR_MASK_CFG_SVH
// What this block does
// - A mask bit of one stops the matching status bit from being reported.
// - The mask never changes a status bit; it still sets and holds.
// - Time-out masks sit at bits 0-2 (ingress) and 4-6 (egress).
// - ECC masks sit at bits 7-14, single then double, in RAM order.
// - Bit 15 parity, bit 16 unreliable link, bits 17-18 replay ECC.
// - Status bits set on detection and clear when software writes one.
// - Severity one reports uncorrectable, severity zero correctable.

// =====================================================
// Register offsets
`define IERR_CTL_OFFSET 12'h480
`define IERR_STS_OFFSET 12'h484
`define IERR_MSK_OFFSET 12'h488
`define IERR_SEV_OFFSET 12'h48C

// =====================================================
// Field layout and reset values
`define IERR_NUM_ERR 19
`define IERR_RSVD_BIT 3
`define IERR_VALID_MASK 32'h0007FFF7
`define IERR_MSK_RESET 32'h00000000
`define IERR_STS_RESET 32'h00000000
`define IERR_SEV_RESET 32'h00000511
`define IERR_CTL_RESET 32'h00000001
`define IERR_CTL_EN_BIT 0
`define IERR_CTL_EN_RESET 1'b1

// =====================================================
// Field positions, time-out group
`define IERR_POS_INGRESS_POSTED_TIMEOUT 0
`define IERR_POS_INGRESS_NONPOSTED_TIMEOUT 1
`define IERR_POS_INGRESS_COMPLETION_TIMEOUT 2
`define IERR_POS_EGRESS_POSTED_TIMEOUT 4
`define IERR_POS_EGRESS_NONPOSTED_TIMEOUT 5
`define IERR_POS_EGRESS_COMPLETION_TIMEOUT 6

// =====================================================
// Field positions, buffer RAM ECC group
`define IERR_POS_INGRESS_DATA_SINGLE_ECC 7
`define IERR_POS_INGRESS_DATA_DOUBLE_ECC 8
`define IERR_POS_INGRESS_CTRL_SINGLE_ECC 9
`define IERR_POS_INGRESS_CTRL_DOUBLE_ECC 10
`define IERR_POS_EGRESS_DATA_SINGLE_ECC 11
`define IERR_POS_EGRESS_DATA_DOUBLE_ECC 12
`define IERR_POS_EGRESS_CTRL_SINGLE_ECC 13
`define IERR_POS_EGRESS_CTRL_DOUBLE_ECC 14

// =====================================================
// Field positions, remaining group
`define IERR_POS_END_TO_END_PARITY_ERROR 15
`define IERR_POS_UNRELIABLE_LINK_FLAG 16
`define IERR_POS_REPLAY_CTRL_SINGLE_ECC 17
`define IERR_POS_REPLAY_CTRL_DOUBLE_ECC 18
`endif

// ### ierr_mask_pkg.sv
package ierr_mask_pkg;
  typedef logic [31:0] word_t;
  // APB request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
  // Report toward the error reporting capability
  typedef struct packed {
    logic uncorrectable;
    logic correctable;
  } err_report_s;
endpackage

// ### ierr_mask_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ierr_mask_asserts (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire ierr_mask_pkg::apb_req_s apbReq,
  input wire logic [31:0] errDetect,
  input wire ierr_mask_pkg::err_report_s errReport,
  input wire logic [31:0] forwardedErr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Write decode, mask and status targets
  wire [31:0] f = forwardedErr;
  wire w = apbReq.psel & apbReq.penable & apbReq.pwrite;
  wire c = w | (|errDetect);
  wire m = w & (apbReq.paddr == 12'h488);
  wire k = w & (apbReq.paddr == 12'h484) & !errDetect;
  a_mask_hide:
  assert property (m |=> !(f & $past(apbReq.pwdata))) else $error("m");
  a_w1c_clear:
  assert property (k |=> !(f & $past(apbReq.pwdata))) else $error("k");
  a_bit_hold:
  assert property (f[0] && !w |=> f[0]) else $error("h");
  a_rsvd_zero:
  assert property (!(f & 32'hFFF80008)) else $error("z");
  a_rise_cause:
  assert property ($rose(|f) |-> $past(c)) else $error("r");
  a_fall_cause:
  assert property ($fell(f[16]) |-> $past(w)) else $error("f");
  a_ecc_hold:
  assert property ((f[7] && !w)[*2] |=> f[7]) else $error("e");
  a_report_src:
  assert property (errReport != 0 |-> f != 0) else $error("s");
endmodule
bind internal_error_report_mask ierr_mask_asserts watch (.clk_sys, .sys_rst,
  .apbReq, .errDetect, .errReport, .forwardedErr);
`default_nettype wire

// ### aer_sink.sv
`timescale 1ns/1ps
`default_nettype none
module aer_sink (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire ierr_mask_pkg::err_report_s rep,
  output logic [1:0] seen
);
  // Latch each report kind seen since reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      seen <= 2'h0;
    end else begin
      seen <= seen | rep;
    end
  end
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ierr_mask_pkg::*;
  logic clk_sys = 0;
  logic sys_rst = 1;
  apb_req_s apbReq = '0;
  word_t errDetect = '0;
  word_t rd, prdata, forwardedErr;
  err_report_s errReport;
  logic pready, pslverr, err;
  logic [1:0] seen;
  int badCount = 0;
  int testsRun = 0;
  // Clock, 5 ns period
  always #2.5 clk_sys = ~clk_sys;
  internal_error_report_mask dut (.clk_sys, .sys_rst, .apbReq, .pready,
    .prdata, .pslverr, .errDetect, .errReport, .forwardedErr);
  aer_sink sink (.clk_sys, .sys_rst, .rep(errReport), .seen);
  task automatic chk(string n, word_t s, word_t e);
    testsRun++;
    if (s !== e) begin
      badCount++;
      $display("Error %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, word_t d);
    @(posedge clk_sys);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apbReq <= '0;
  endtask
  task automatic s_regs;
    apb(0, 12'h488, 0);
    chk("mask", rd, 0);
    apb(0, 12'h48C, 0);
    chk("sev", rd, 32'h511);
    chk("slverr", 32'(err), 0);
    apb(1, 12'h488, '1);
    apb(0, 12'h488, 0);
    chk("rsvd", rd, 32'h7FFF7);
    apb(0, 12'h400, 0);
    chk("unmapped", rd, 0);
    chk("slverr", 32'(err), 1);
  endtask
  task automatic s_mask;
    errDetect <= '1;
    @(posedge clk_sys);
    errDetect <= '0;
    apb(1, 12'h488, 32'h55555);
    @(negedge clk_sys);
    chk("fwd", forwardedErr, 32'h2AAA2);
    apb(0, 12'h484, 0);
    chk("sts", rd, 32'h7FFF7);
    apb(1, 12'h488, 32'h2AAAA);
    @(negedge clk_sys);
    chk("fwd", forwardedErr, 32'h55555);
    chk("rep", 32'(errReport), 3);
    apb(1, 12'h48C, 0);
    @(negedge clk_sys);
    chk("rep", 32'(errReport), 1);
    apb(1, 12'h480, 0);
    @(negedge clk_sys);
    chk("off", 32'(errReport), 0);
    chk("held", forwardedErr, 32'h55555);
    apb(1, 12'h480, 1);
    apb(1, 12'h484, '1);
    @(negedge clk_sys);
    chk("clr", forwardedErr, 0);
  endtask
  task automatic s_reset;
    apb(1, 12'h488, '1);
    sys_rst <= 1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 0;
    apb(0, 12'h488, 0);
    chk("mask", rd, 0);
    chk("aer", 32'(seen), 0);
  endtask
  task automatic giveVerdict;
    $display("checks %0d errors %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #20us;
    badCount++;
    giveVerdict();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 0;
    s_regs();
    s_mask();
    chk("aer", 32'(seen), 3);
    s_reset();
    giveVerdict();
  end
endmodule
`default_nettype wire
